// ==== src/hpoi_pkg.sv ====
`default_nettype none
package hpoi_pkg;
   localparam int CLK_PS = 10000;
   localparam int OOB_BURST_PS = 106700;
   localparam int OOB_GAP_RESET_PS = 320000;
   localparam int OOB_GAP_WAKE_PS = 106700;
   localparam int OOB_NBURST = 6;
   localparam int XTALK_PS = 116300;
   localparam int OOB_BURST_CYC = (OOB_BURST_PS + CLK_PS - 1) / CLK_PS;
   localparam int OOB_GAP_RESET_CYC = (OOB_GAP_RESET_PS + CLK_PS - 1) / CLK_PS;
   localparam int OOB_GAP_WAKE_CYC = (OOB_GAP_WAKE_PS + CLK_PS - 1) / CLK_PS;
   localparam int XTALK_CYC = (XTALK_PS + CLK_PS - 1) / CLK_PS;
   // Gen1 dword is 8/3 clock cycles
   localparam int DW_NUM = 3;
   localparam int DW_DEN = 8;
   localparam int ALIGN_TO_DW = 32768;
   localparam logic [1:0] NONALIGN_RUN = 2'h3;
   localparam logic [7:0] K28_3 = 8'h7c;
   localparam logic [7:0] K28_5 = 8'hbc;
   localparam logic [31:0] ALIGN_WORD = 32'h7b4a4abc;
   localparam logic [31:0] D10_2_WORD = 32'h4a4a4a4a;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TOCNT = 8'h08;
   localparam int CTRL_CAL_EN = 0;
   localparam int CTRL_RETRY_OFF = 1;
   localparam int CTRL_SOFT_RST = 2;
   localparam int STAT_PHYRDY = 4;
   localparam int STAT_HALT = 5;
   localparam int STAT_INIT = 6;
   localparam int STAT_WAKE = 7;
   typedef enum logic [3:0] {
      ST_RESET, ST_AWAIT_INIT, ST_AWAIT_NO_INIT, ST_CALIB, ST_WAKE_SEND,
      ST_AWAIT_WAKE, ST_AWAIT_NO_WAKE, ST_AWAIT_ALIGN, ST_ADJUST,
      ST_SEND_ALIGN, ST_READY, ST_PARTIAL, ST_SLUMBER
   } hpoi_state_t;
endpackage
`default_nettype wire

// ==== src/hpoi_aux_if.sv ====
`default_nettype none
interface hpoi_aux_if;
   logic oob_start;
   logic oob_wake;
   logic oob_burst;
   logic oob_busy;
   logic dw_tick;
   modport ctl(output oob_start, oob_wake, input oob_burst, oob_busy, dw_tick);
   modport gen(input oob_start, oob_wake, output oob_burst, oob_busy);
   modport tick(output dw_tick);
endinterface
`default_nettype wire

// ==== src/hpoi_dw_tick.sv ====
`default_nettype none
module hpoi_dw_tick import hpoi_pkg::*; (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Dword tick
   hpoi_aux_if.tick aux
);
   logic [3:0] acc;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc <= 4'h0;
         aux.dw_tick <= 1'b0;
      end else if (acc + 4'(DW_NUM) >= 4'(DW_DEN)) begin
         acc <= acc + 4'(DW_NUM) - 4'(DW_DEN);
         aux.dw_tick <= 1'b1;
      end else begin
         acc <= acc + 4'(DW_NUM);
         aux.dw_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== src/hpoi_oob_gen.sv ====
`default_nettype none
module hpoi_oob_gen import hpoi_pkg::*; #(
   parameter int NBURST = OOB_NBURST,
   parameter int BURST_CYC = OOB_BURST_CYC,
   parameter int GAP_RST_CYC = OOB_GAP_RESET_CYC,
   parameter int GAP_WAKE_CYC = OOB_GAP_WAKE_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Burst control
   hpoi_aux_if.gen aux
);
   logic wk;
   logic [3:0] bcnt;
   logic [7:0] ccnt;
   logic [7:0] gap_end;

   assign gap_end = wk ? 8'(GAP_WAKE_CYC - 1) : 8'(GAP_RST_CYC - 1);

   // Bursts of fixed length, each followed by a gap
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aux.oob_busy <= 1'b0;
         aux.oob_burst <= 1'b0;
         wk <= 1'b0;
         bcnt <= 4'h0;
         ccnt <= 8'h00;
      // A reset sequence cuts a running wake sequence short
      end else if (!aux.oob_busy || (aux.oob_start && !aux.oob_wake && wk)) begin
         if (aux.oob_start) begin
            aux.oob_busy <= 1'b1;
            aux.oob_burst <= 1'b1;
            wk <= aux.oob_wake;
            bcnt <= 4'h0;
            ccnt <= 8'h00;
         end
      end else if (aux.oob_burst) begin
         ccnt <= ccnt + 8'h01;
         if (ccnt == 8'(BURST_CYC - 1)) begin
            aux.oob_burst <= 1'b0;
            ccnt <= 8'h00;
         end
      end else begin
         ccnt <= ccnt + 8'h01;
         if (ccnt == gap_end) begin
            ccnt <= 8'h00;
            if (bcnt == 4'(NBURST - 1)) begin
               aux.oob_busy <= 1'b0; // [RULE3]
            end else begin
               bcnt <= bcnt + 4'h1;
               aux.oob_burst <= 1'b1; // [RULE23]
            end
         end
      end
   end

   a_burst_six: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
      $fell(aux.oob_busy) |-> $past(bcnt) == 4'(NBURST - 1))
      else $error("burst sequence did not hold six bursts");
endmodule
`default_nettype wire

// ==== src/hpoi_host_init.sv ====
// Overview of operation
// RULE1: Received init from far end forces wait-for-init-release unless reset holds.
// RULE2: Power-on reset or adapter reset request forces the reset state.
// RULE3: Reset burst sequence is exactly six bursts.
// RULE4: Reset bursts are sent on leaving reset, possibly finishing afterwards.
// RULE5: Without reset sources, reset moves on to wait-for-init.
// RULE6: Wait-for-init holds until init detector asserts.
// RULE7: Wait-for-init-release holds while init asserted, then advances.
// RULE8: Calibration runs only when enabled; otherwise go straight to wake send.
// RULE9: Wake send transmits bursts, then branches on wake detector level.
// RULE10: Wait-for-wake holds until wake detector asserts.
// RULE11: Wait-for-wake-release holds while wake asserted, then await alignment.
// RULE12: Await alignment sends D10.2 at lowest rate within twenty dwords.
// RULE13: Far end may idle up to two dwords before sending characters.
// RULE14: Received characters ignored for 116.3 ns after wake release.
// RULE15: Alignment primitive in await alignment moves to speed adjust.
// RULE16: No alignment within 32768 dwords returns to reset.
// RULE17: Timeouts retry forever unless software disables retrying. The code ignores a send-alignment timeout while retrying is on.
// RULE18: Speed adjust waits for rate change, then sends alignment.
// RULE19: Send alignment until three consecutive non-alignment words, then ready.
// RULE20: Non-alignment word has K28.3 in byte 0.
// RULE21: Ready passes link words and raises phy ready.
// RULE22: Ready goes to partial or slumber on link layer requests.
// RULE23: Each burst has fixed length followed by idle gap.
// RULE24: Alignment timeout counts dwords, cleared on entering await alignment.
// RULE25: Detector levels are synchronized and transitions evaluated every cycle.
`default_nettype none
module hpoi_host_init import hpoi_pkg::*; #(
   parameter int ALIGN_TO = ALIGN_TO_DW,
   parameter int TO_W = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Reset source and analog status
   input wire logic host_reset_req,
   input wire logic init_det,
   input wire logic wake_det,
   input wire logic cal_done,
   input wire logic speed_done,
   // Receive link
   input wire logic link_clk,
   input wire logic [31:0] rx_data,
   input wire logic rx_k0,
   // Link layer
   input wire logic partial_req,
   input wire logic slumber_req,
   input wire logic [31:0] link_tx_data,
   input wire logic link_tx_k0,
   // Transmit and status
   output logic oob_burst,
   output logic [31:0] tx_data,
   output logic tx_k0,
   output logic cal_start,
   output logic speed_adjust,
   output logic phy_rdy,
   output logic pm_partial,
   output logic pm_slumber
);
   localparam int SW = 39;
   logic rs1, rst_sync_n;
   logic [SW-1:0] s1, s2;
   logic host_req_s, init_s, wake_s, cal_done_s, speed_done_s, lclk_s, rx_k0_s;
   logic [31:0] rx_s;
   logic lclk_d, rx_stb;
   logic [31:0] rx_word;
   logic rx_k0_w;
   logic align_det, nonalign_det, align_seen;
   hpoi_state_t state, state_q, next_state;
   logic cal_en, retry_off, soft_rst, halted;
   logic reset_req, timeout, wake_issued, wake_start, rst_start;
   logic [TO_W-1:0] dw_cnt;
   logic [7:0] ign_cnt;
   logic [1:0] na_cnt;
   hpoi_aux_if aux();

   ////////////////////////////////////////////////////////////
   // Reset release and input synchronisers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rs1 <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rs1 <= 1'b1;
         rst_sync_n <= rs1;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s1 <= '0;
         s2 <= '0;
      end else begin
         s1 <= {host_reset_req, init_det, wake_det, cal_done, speed_done,
                link_clk, rx_k0, rx_data}; // [RULE25]
         s2 <= s1;
      end
   end

   assign {host_req_s, init_s, wake_s, cal_done_s, speed_done_s,
           lclk_s, rx_k0_s, rx_s} = s2;

   ////////////////////////////////////////////////////////////
   // Receive word capture on link clock rising edge
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lclk_d <= 1'b0;
         rx_stb <= 1'b0;
         rx_word <= 32'h0;
         rx_k0_w <= 1'b0;
      end else begin
         lclk_d <= lclk_s;
         rx_stb <= lclk_s & ~lclk_d;
         if (lclk_s & ~lclk_d) begin
            rx_word <= rx_s;
            rx_k0_w <= rx_k0_s;
         end
      end
   end

   assign align_det = rx_stb && rx_k0_w && rx_word[7:0] == K28_5;
   assign nonalign_det = rx_stb && rx_k0_w && rx_word[7:0] == K28_3; // [RULE20]
   assign align_seen = align_det && ign_cnt == 8'h00; // [RULE14]

   ////////////////////////////////////////////////////////////
   // Helper blocks
   hpoi_dw_tick u_tick (
      .clock(clock),
      .rst_n(rst_sync_n),
      .aux(aux.tick)
   );

   hpoi_oob_gen u_oob (
      .clock(clock),
      .rst_n(rst_sync_n),
      .aux(aux.gen)
   );

   assign rst_start = state == ST_RESET && next_state != ST_RESET; // [RULE4]
   assign wake_start = state == ST_WAKE_SEND && !wake_issued && !aux.oob_busy;
   assign aux.oob_start = rst_start | wake_start;
   assign aux.oob_wake = wake_start;
   assign oob_burst = aux.oob_burst;

   ////////////////////////////////////////////////////////////
   // Next state
   assign reset_req = host_req_s | soft_rst;
   assign timeout = dw_cnt == TO_W'(ALIGN_TO);

   always_comb begin
      next_state = state;
      case (state)
         ST_RESET: if (!(halted && retry_off)) next_state = ST_AWAIT_INIT; // [RULE5] [RULE17]
         ST_AWAIT_INIT: if (init_s) next_state = ST_AWAIT_NO_INIT; // [RULE6]
         ST_AWAIT_NO_INIT: if (!init_s) begin // [RULE7]
            next_state = cal_en ? ST_CALIB : ST_WAKE_SEND; // [RULE8]
         end
         ST_CALIB: if (cal_done_s) next_state = ST_WAKE_SEND; // [RULE8]
         ST_WAKE_SEND: if (wake_issued && !aux.oob_busy) begin // [RULE9]
            next_state = wake_s ? ST_AWAIT_NO_WAKE : ST_AWAIT_WAKE;
         end
         ST_AWAIT_WAKE: if (wake_s) next_state = ST_AWAIT_NO_WAKE; // [RULE10]
         ST_AWAIT_NO_WAKE: if (!wake_s) next_state = ST_AWAIT_ALIGN; // [RULE11]
         ST_AWAIT_ALIGN: begin
            if (align_seen) next_state = ST_ADJUST; // [RULE15]
            else if (timeout) next_state = ST_RESET; // [RULE16]
         end
         ST_ADJUST: if (speed_done_s) next_state = ST_SEND_ALIGN; // [RULE18]
         ST_SEND_ALIGN: begin
            if (na_cnt == NONALIGN_RUN) next_state = ST_READY; // [RULE19]
            else if (retry_off && timeout) next_state = ST_RESET;
         end
         ST_READY: begin
            if (partial_req) next_state = ST_PARTIAL; // [RULE22]
            else if (slumber_req) next_state = ST_SLUMBER; // [RULE22]
         end
         ST_PARTIAL: if (!partial_req) begin
            next_state = wake_s ? ST_AWAIT_NO_WAKE : ST_WAKE_SEND;
         end
         ST_SLUMBER: if (!slumber_req) begin
            next_state = wake_s ? ST_AWAIT_NO_WAKE : ST_WAKE_SEND;
         end
         default: next_state = ST_RESET;
      endcase
      if (init_s) next_state = ST_AWAIT_NO_INIT; // [RULE1]
      if (reset_req) next_state = ST_RESET; // [RULE2]
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= ST_RESET; // [RULE2]
         state_q <= ST_RESET;
      end else begin
         state <= next_state;
         state_q <= state;
      end
   end

   ////////////////////////////////////////////////////////////
   // Wake burst bookkeeping
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wake_issued <= 1'b0;
      end else if (state != ST_WAKE_SEND) begin
         wake_issued <= 1'b0;
      end else if (wake_start) begin
         wake_issued <= 1'b1; // [RULE9]
      end
   end

   ////////////////////////////////////////////////////////////
   // Dword timeout, crosstalk guard and non-alignment run
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dw_cnt <= '0;
      end else if (state != state_q) begin
         dw_cnt <= '0; // [RULE24]
      end else if (aux.dw_tick && !timeout) begin
         dw_cnt <= dw_cnt + 1'b1; // [RULE24]
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ign_cnt <= 8'(XTALK_CYC);
      end else if (state != ST_AWAIT_ALIGN) begin
         ign_cnt <= 8'(XTALK_CYC); // [RULE14]
      end else if (ign_cnt != 8'h00) begin
         ign_cnt <= ign_cnt - 8'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         na_cnt <= 2'h0;
      end else if (state != ST_SEND_ALIGN) begin
         na_cnt <= 2'h0;
      end else if (rx_stb) begin
         if (!nonalign_det) na_cnt <= 2'h0; // [RULE19]
         else if (na_cnt != NONALIGN_RUN) na_cnt <= na_cnt + 2'h1;
      end
   end

   // Retry halt after timeout while retrying is off
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         halted <= 1'b0;
      end else begin
         if (!retry_off || reset_req) halted <= 1'b0;
         if (retry_off && timeout && next_state == ST_RESET && !reset_req) begin
            halted <= 1'b1; // [RULE17]
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Transmit path and status outputs
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_data <= 32'h0;
         tx_k0 <= 1'b0;
      end else begin
         case (state)
            ST_AWAIT_ALIGN: begin
               tx_data <= D10_2_WORD; // [RULE12]
               tx_k0 <= 1'b0;
            end
            ST_ADJUST, ST_SEND_ALIGN: begin
               tx_data <= ALIGN_WORD; // [RULE18] [RULE19]
               tx_k0 <= 1'b1;
            end
            ST_READY: begin
               tx_data <= link_tx_data; // [RULE21]
               tx_k0 <= link_tx_k0;
            end
            default: begin
               tx_data <= 32'h0;
               tx_k0 <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phy_rdy <= 1'b0;
         cal_start <= 1'b0;
         speed_adjust <= 1'b0;
         pm_partial <= 1'b0;
         pm_slumber <= 1'b0;
      end else begin
         phy_rdy <= state == ST_READY; // [RULE21]
         cal_start <= state == ST_CALIB;
         speed_adjust <= state == ST_ADJUST;
         pm_partial <= state == ST_PARTIAL;
         pm_slumber <= state == ST_SLUMBER;
      end
   end

   ////////////////////////////////////////////////////////////
   // Register port
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cal_en <= 1'b0;
         retry_off <= 1'b0;
         soft_rst <= 1'b0;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         cal_en <= reg_wdata[CTRL_CAL_EN];
         retry_off <= reg_wdata[CTRL_RETRY_OFF];
         soft_rst <= reg_wdata[CTRL_SOFT_RST];
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               REG_CTRL: begin
                  reg_rdata[CTRL_CAL_EN] <= cal_en;
                  reg_rdata[CTRL_RETRY_OFF] <= retry_off;
                  reg_rdata[CTRL_SOFT_RST] <= soft_rst;
               end
               REG_STATUS: begin
                  reg_rdata[3:0] <= state;
                  reg_rdata[STAT_PHYRDY] <= phy_rdy;
                  reg_rdata[STAT_HALT] <= halted;
                  reg_rdata[STAT_INIT] <= init_s;
                  reg_rdata[STAT_WAKE] <= wake_s;
               end
               REG_TOCNT: reg_rdata[TO_W-1:0] <= dw_cnt;
               default: reg_rdata <= 32'h0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_sync_n);

   a_init_jump: assert property ((init_s && !reset_req) |=> state == ST_AWAIT_NO_INIT) // [RULE1]
      else $error("init did not force wait for init release");
   a_reset_entry: assert property (reset_req |=> state == ST_RESET) // [RULE2]
      else $error("reset request did not force reset state");
   a_leave_reset: assert property ((state == ST_RESET && !reset_req && !init_s // [RULE5]
      && !(halted && retry_off)) |=> state == ST_AWAIT_INIT)
      else $error("reset state not left");
   a_hold_init: assert property ((state == ST_AWAIT_INIT && !init_s && !reset_req) // [RULE6]
      |=> state == ST_AWAIT_INIT)
      else $error("left wait for init without init");
   a_calib_path: assert property ((state == ST_AWAIT_NO_INIT && !init_s && !reset_req) // [RULE7]
      |=> (cal_en ? state == ST_CALIB : state == ST_WAKE_SEND))
      else $error("wrong step after init release");
   a_d102_send: assert property ($rose(state == ST_AWAIT_ALIGN) // [RULE12]
      |=> tx_data == D10_2_WORD || state != ST_AWAIT_ALIGN)
      else $error("D10.2 not sent in await alignment");
   a_xtalk_guard: assert property ((state == ST_AWAIT_ALIGN && $past(state) != ST_AWAIT_ALIGN) // [RULE14]
      |-> !align_seen [*8])
      else $error("alignment accepted inside guard time");
   a_align_timeout: assert property ((state == ST_AWAIT_ALIGN && timeout && !align_seen // [RULE16]
      && !init_s && !reset_req) |=> state == ST_RESET)
      else $error("alignment timeout missed");
   a_ready_run: assert property ((state == ST_SEND_ALIGN && na_cnt == NONALIGN_RUN // [RULE19]
      && !init_s && !reset_req) |=> state == ST_READY ##1 phy_rdy)
      else $error("ready not reached after non-alignment run");
   a_power_req: assert property ((state == ST_READY && partial_req && !init_s && !reset_req) // [RULE22]
      |=> state == ST_PARTIAL ##1 pm_partial && !phy_rdy)
      else $error("partial request ignored");
endmodule
`default_nettype wire

// ==== dv/hpoi_dev_model.sv ====
`default_nettype none
module hpoi_dev_model import hpoi_pkg::*; (
   // Clock and control
   input wire logic clock,
   input wire logic align_on,
   // From host
   input wire logic oob_burst,
   input wire logic [31:0] tx_data,
   input wire logic tx_k0,
   // To host
   output logic init_det,
   output logic wake_det,
   output logic link_clk,
   output logic [31:0] rx_data,
   output logic rx_k0
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap;
   initial begin
      init_det = 1'b0;
      wake_det = 1'b0;
      link_clk = 1'b0;
      rx_data = 32'h0;
      rx_k0 = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic send_words();
      repeat (30) begin
         rx_k0 = 1'b1;
         if (tx_data === ALIGN_WORD && tx_k0 === 1'b1)
            rx_data = {24'h4a4a4a, K28_3};
         else
            rx_data = ALIGN_WORD;
         #80 link_clk = 1'b1;
         #80 link_clk = 1'b0;
      end
      // Released line must not keep a valid look
      rx_data = ~rx_data;
      rx_k0 = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always begin
      @(posedge oob_burst);
      @(negedge oob_burst);
      gap = 0;
      while (!oob_burst && gap < 40) begin
         @(negedge clock);
         gap++;
      end
      // Kind told by spacing, not by burst length
      repeat (4) @(posedge oob_burst);
      @(negedge oob_burst);
      // Detector levels and link edges move off the host's sampling edge
      repeat (45) @(negedge clock);
      if (gap > 20) begin
         init_det = 1'b1;
         repeat (30) @(negedge clock);
         init_det = 1'b0;
      end else begin
         wake_det = 1'b1;
         repeat (30) @(negedge clock);
         wake_det = 1'b0;
         if (align_on)
            send_words();
      end
   end
endmodule
`default_nettype wire

// ==== dv/hpoi_host_init_bench.sv ====
`default_nettype none
module hpoi_host_init_bench import hpoi_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic host_reset_req = 1'b0;
   logic cal_done = 1'b0;
   logic speed_done = 1'b0;
   logic partial_req = 1'b0;
   logic slumber_req = 1'b0;
   logic [31:0] link_tx_data = 32'h0;
   logic link_tx_k0 = 1'b0;
   logic align_on = 1'b1;
   logic [31:0] reg_rdata, tx_data, rx_data, rd;
   logic init_det, wake_det, link_clk, rx_k0, oob_burst, tx_k0;
   logic cal_start, speed_adjust, phy_rdy, pm_partial, pm_slumber;
   int errors = 0;
   int checks = 0;
   int bursts = 0;
   int cycles = 0;
   int d10;
   int n;
   always #5 clock = ~clock;
   hpoi_host_init #(.ALIGN_TO(64), .TO_W(16)) i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .host_reset_req(host_reset_req), .init_det(init_det), .wake_det(wake_det), .cal_done(cal_done),
      .speed_done(speed_done), .link_clk(link_clk), .rx_data(rx_data), .rx_k0(rx_k0),
      .partial_req(partial_req), .slumber_req(slumber_req), .link_tx_data(link_tx_data),
      .link_tx_k0(link_tx_k0), .oob_burst(oob_burst), .tx_data(tx_data), .tx_k0(tx_k0),
      .cal_start(cal_start), .speed_adjust(speed_adjust), .phy_rdy(phy_rdy), .pm_partial(pm_partial),
      .pm_slumber(pm_slumber));
   hpoi_dev_model i_dev (.clock(clock), .align_on(align_on), .oob_burst(oob_burst), .tx_data(tx_data),
      .tx_k0(tx_k0), .init_det(init_det), .wake_det(wake_det), .link_clk(link_clk), .rx_data(rx_data),
      .rx_k0(rx_k0));
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) speed_done <= speed_adjust;
   always @(posedge oob_burst) bursts++;
   always @(negedge wake_det) begin
      if (rst_n === 1'b1) begin
         d10 = 0;
         while (tx_data !== D10_2_WORD && d10 < 60) begin
            @(posedge clock);
            d10++;
         end
         chk32("d10_delay", 32'h1, 32'(d10 <= 53));
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         complete_run();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("Checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      // Read data stand only in the cycle after the strobe
      @(posedge clock);
      rd = reg_rdata;
   endtask
   task automatic wait_rdy();
      repeat (4000) if (phy_rdy !== 1'b1) @(posedge clock);
      chk32("phy_rdy", 32'h1, {31'h0, phy_rdy});
   endtask
   task automatic restart(input logic pin, input logic [31:0] ctrl);
      if (pin)
         host_reset_req <= 1'b1;
      reg_write(REG_CTRL, ctrl | (32'(!pin) << CTRL_SOFT_RST));
      // Let the far side finish its last character run
      repeat (500) @(posedge clock);
      reg_read(REG_STATUS);
      chk32("reset_state", {28'h0, 4'(ST_RESET)}, {28'h0, rd[3:0]});
      chk32("rdy_off", 32'h0, {31'h0, phy_rdy});
      bursts = 0;
      host_reset_req <= 1'b0;
      reg_write(REG_CTRL, ctrl);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_bringup();
      wait_rdy();
      chk32("bursts", 32'd12, bursts);
      link_tx_data <= 32'h13572468;
      link_tx_k0 <= 1'b1;
      repeat (3) @(posedge clock);
      chk32("tx_link", 32'h13572468, tx_data);
      chk32("tx_k0", 32'h1, {31'h0, tx_k0});
      $display("Test bringup done");
   endtask
   task automatic t_regs();
      reg_read(8'h0c);
      chk32("unmapped", 32'h0, rd);
      reg_write(REG_STATUS, 32'hffffffff);
      reg_read(REG_STATUS);
      chk32("status", 32'(ST_READY) | (32'h1 << STAT_PHYRDY), rd & 32'hff);
      $display("Test registers done");
   endtask
   task automatic t_cal();
      restart(1'b0, 32'h1);
      repeat (3000) if (cal_start !== 1'b1) @(posedge clock);
      repeat (200) @(posedge clock);
      chk32("cal_hold", 32'h1, {31'h0, cal_start & ~phy_rdy});
      cal_done <= 1'b1;
      wait_rdy();
      cal_done <= 1'b0;
      reg_write(REG_CTRL, 32'h0);
      $display("Test calibration done");
   endtask
   task automatic t_power();
      for (int i = 0; i < 2; i++) begin
         repeat (500) @(posedge clock);
         partial_req <= (i == 0);
         slumber_req <= (i == 1);
         repeat (8) @(posedge clock);
         chk32("pm", 32'(i + 1), {29'h0, phy_rdy, pm_slumber, pm_partial});
         partial_req <= 1'b0;
         slumber_req <= 1'b0;
         wait_rdy();
      end
      $display("Test power done");
   endtask
   task automatic t_timeout();
      align_on <= 1'b0;
      restart(1'b1, 32'h0);
      repeat (6000) if (bursts < 18) @(posedge clock);
      chk32("retry", 32'd18, bursts);
      reg_write(REG_CTRL, 32'h1 << CTRL_RETRY_OFF);
      rd = 32'h0;
      repeat (800) if (rd[STAT_HALT] !== 1'b1) reg_read(REG_STATUS);
      chk32("halted", 32'(ST_RESET) | (32'h1 << STAT_HALT), rd & 32'hff);
      n = bursts;
      repeat (600) @(posedge clock);
      chk32("no_retry", 32'(n), bursts);
      align_on <= 1'b1;
      reg_write(REG_CTRL, 32'h0);
      wait_rdy();
      $display("Test timeout done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      t_bringup();
      t_regs();
      t_cal();
      t_power();
      t_timeout();
      complete_run();
   end
endmodule
`default_nettype wire
